// ### design/gpcfg_pkg.sv
// Purpose: Constants for the per-pin configuration access block
// Assumes: Byte-wide register port, index addressing
// Notes: Pin index is port*8+pin, 40 slots of which 37 are real
package gpcfg_pkg;
    localparam int GPCFG_AW = 8;
    localparam int GPCFG_DW = 8;
    localparam logic [7:0] GPCFG_OFF_SEL = 8'hf0;
    localparam logic [7:0] GPCFG_OFF_CFG = 8'hf1;
    localparam logic [7:0] GPCFG_OFF_RTE = 8'hf2;
    localparam logic [7:0] GPCFG_OFF_GCFG = 8'hf3;
    localparam int GPCFG_SEL_PORT_LSB = 4;
    localparam int GPCFG_SEL_PIN_LSB = 0;
    localparam logic [7:0] GPCFG_SEL_MASK = 8'h77;
    localparam logic [7:0] GPCFG_SEL_RST = 8'h00;
    localparam int GPCFG_CFG_DEB = 6;
    localparam int GPCFG_CFG_POL = 5;
    localparam int GPCFG_CFG_TYP = 4;
    localparam int GPCFG_CFG_LOCK = 3;
    localparam int GPCFG_CFG_PU = 2;
    localparam int GPCFG_CFG_OT = 1;
    localparam int GPCFG_CFG_OE = 0;
    localparam logic [7:0] GPCFG_CFG_RST_EV = 8'h44;
    localparam logic [7:0] GPCFG_CFG_RST_NOEV = 8'h04;
    localparam logic [7:0] GPCFG_CFG_MASK_EV = 8'h7f;
    localparam logic [7:0] GPCFG_CFG_MASK_NOEV = 8'h0f;
    localparam logic [7:0] GPCFG_CFG_LOCKED = 8'h0f;
    localparam int GPCFG_RTE_PWU = 2;
    localparam int GPCFG_RTE_SMI = 1;
    localparam int GPCFG_RTE_IRQ = 0;
    localparam logic [7:0] GPCFG_RTE_RST = 8'h01;
    localparam logic [7:0] GPCFG_RTE_MASK = 8'h07;
    localparam int GPCFG_GCFG_MUXLOCK = 7;
    localparam logic [7:0] GPCFG_GCFG_RST = 8'h00;
    localparam logic [7:0] GPCFG_GCFG_MASK = 8'h01;
    localparam int GPCFG_NPORT = 5;
    localparam int GPCFG_NSLOT = 40;
    localparam real GPCFG_DEB_NS = 16000.0;
    localparam int GPCFG_CLK_NS = 10;
    localparam int GPCFG_DEB_CYC = int'($ceil(GPCFG_DEB_NS / GPCFG_CLK_NS));
endpackage

// ### design/gpcfg_mem.sv
// Purpose: Small write-through store for per-pin bytes
// Assumes: One write and one read port, same clock
// Notes: Read data registered; init values come from a vector
`timescale 1ns/100ps
`default_nettype none
module gpcfg_mem #(
    parameter int DEPTH = 40,
    parameter int AW = 6
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic [DEPTH*8-1:0] init_val,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [7:0] wdata,
    input wire logic [AW-1:0] raddr,
    output logic [7:0] rdata,
    output logic [DEPTH*8-1:0] all_q
);
    logic [7:0] mem_r [DEPTH];
    logic init_done_r;

    // Store loads the init_val port vector while reset is held and in the first cycle after release
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            init_done_r <= 1'b0;
        end else begin
            init_done_r <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        for (int i = 0; i < DEPTH; i++) begin
            if (!init_done_r) begin
                mem_r[i] <= init_val[i*8 +: 8];
            end else if (we && waddr == AW'(i)) begin
                mem_r[i] <= wdata;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rdata <= 8'h00;
        end else begin
            rdata <= mem_r[raddr];
        end
    end

    always_comb begin
        for (int i = 0; i < DEPTH; i++) begin
            all_q[i*8 +: 8] = init_done_r ? mem_r[i] : init_val[i*8 +: 8];
        end
    end
endmodule
`default_nettype wire

// ### design/gpcfg_top.sv
// Purpose: Per-pin configuration access for a 37-pin general-purpose port block
// Assumes: Register index port, read data one cycle after the read strobe
// Notes: Pin inputs are synchronised, then optionally debounced for event use
// Summary of operation
// [R01] Port-select field bits 6-4 picks port 0-4, other codes reserved
// [R02] Pin-select field bits 2-0 picks pin 0-7 in chosen port
// [R03] Configuration window reads and writes the selected pin's register
// [R04] Reset value 44h for ports 0,1,4 and 04h for ports 2,3
// [R05] Bit 6 enables debounce of event input, default on
// [R06] Bit 5 picks event polarity, 0 falling or low
// [R07] Bit 4 picks edge (0) or level (1) detection
// [R08] Ports 2 and 3 read bits 6-4 as zero
// [R09] Lock bit 3 freezes direction, type, pull-up, output; only reset clears
// [R10] Lock leaves pin multiplexing free until global mux-lock bit 7 set
// [R11] Bit 2 enables internal pull-up, default on
// [R12] Bit 1 picks open-drain (0) or push-pull (1)
// [R13] Bit 0 enables output driver; input path unaffected
// [R14] Routing register exists only for ports 0, 1 and 4
// [R15] Routing bits: 2 power-up request, 1 mgmt interrupt, 0 IRQ
// [R16] IRQ routing defaults on, others off
// [R17] Port 1 pin 5 is output only, no input or event
// [R18] Pin selector resets to zero
// [R19] Routing reset value has IRQ bit set
// [R20] Reserved port code: window writes ignored, reads zero
//
// The plain strobed port was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module gpcfg_top
    import gpcfg_pkg::*;
#(
    parameter int DEB_CYC = gpcfg_pkg::GPCFG_DEB_CYC
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic [gpcfg_pkg::GPCFG_AW-1:0] reg_addr,
    input wire logic [gpcfg_pkg::GPCFG_DW-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [gpcfg_pkg::GPCFG_DW-1:0] reg_rdata,
    input wire logic [gpcfg_pkg::GPCFG_NSLOT-1:0] pin_in,
    input wire logic [gpcfg_pkg::GPCFG_NSLOT-1:0] pin_dout,
    input wire logic [gpcfg_pkg::GPCFG_NSLOT-1:0] pin_mux_req,
    output logic [gpcfg_pkg::GPCFG_NSLOT-1:0] pin_out,
    output logic [gpcfg_pkg::GPCFG_NSLOT-1:0] pin_oe,
    output logic [gpcfg_pkg::GPCFG_NSLOT-1:0] pin_pullup,
    output logic [gpcfg_pkg::GPCFG_NSLOT-1:0] pin_mux_sel,
    output logic [gpcfg_pkg::GPCFG_NSLOT-1:0] pin_event,
    output logic [gpcfg_pkg::GPCFG_NSLOT-1:0] ev_irq,
    output logic [gpcfg_pkg::GPCFG_NSLOT-1:0] ev_system_mgmt_interrupt,
    output logic [gpcfg_pkg::GPCFG_NSLOT-1:0] ev_power_up_request,
    output logic mux_locked
);
    import gpcfg_pkg::*;

    localparam int N = GPCFG_NSLOT;
    localparam int DW = $clog2(DEB_CYC + 1);

    function automatic logic has_event(input logic [2:0] port);
        has_event = (port == 3'd0) || (port == 3'd1) || (port == 3'd4);
    endfunction

    function automatic logic slot_real(input int s);
        slot_real = !((s / 8 == 3) && (s % 8 > 4));
    endfunction

    function automatic logic [7:0] cfg_mask(input logic [2:0] port);
        cfg_mask = has_event(port) ? GPCFG_CFG_MASK_EV : GPCFG_CFG_MASK_NOEV;
    endfunction

    logic [7:0] sel_r;
    logic [7:0] gcfg_r;
    logic [2:0] port_sel;
    logic [5:0] slot_sel;
    logic port_ok;
    logic [N*8-1:0] cfg_init;
    logic [N*8-1:0] cfg_all;
    logic [N*8-1:0] rte_init;
    logic [N*8-1:0] rte_all;
    logic [7:0] cfg_rd;
    logic [7:0] rte_rd;
    logic [7:0] cfg_old;
    logic [7:0] cfg_wval;
    logic cfg_we;
    logic rte_we;
    logic [7:0] rd_addr_r;
    logic rd_ok_r;
    logic rd_ev_r;
    logic [N-1:0] in_s1_r;
    logic [N-1:0] in_s2_r;
    logic [N-1:0] in_deb_r;
    logic [N-1:0] in_prev_r;
    logic [DW-1:0] deb_cnt_r [N];
    logic [N-1:0] ev_ok;

    assign port_sel = sel_r[GPCFG_SEL_PORT_LSB +: 3]; // see [R01]
    assign slot_sel = {port_sel, sel_r[GPCFG_SEL_PIN_LSB +: 3]}; // see [R02]
    assign port_ok = port_sel <= 3'd4; // see [R20]
    assign mux_locked = gcfg_r[GPCFG_GCFG_MUXLOCK];

    always_comb begin
        for (int s = 0; s < N; s++) begin
            cfg_init[s*8 +: 8] = has_event(3'(s / 8)) ? GPCFG_CFG_RST_EV : GPCFG_CFG_RST_NOEV; // see [R04]
            rte_init[s*8 +: 8] = GPCFG_RTE_RST; // see [R16] see [R19]
            ev_ok[s] = has_event(3'(s / 8)) && !(s == 13); // see [R17]
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            sel_r <= GPCFG_SEL_RST; // see [R18]
        end else if (reg_wr && reg_addr == GPCFG_OFF_SEL) begin
            sel_r <= reg_wdata & GPCFG_SEL_MASK;
        end
    end

    // Global lock is sticky; once set, mux selection freezes
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            gcfg_r <= GPCFG_GCFG_RST;
        end else if (reg_wr && reg_addr == GPCFG_OFF_GCFG) begin
            gcfg_r[GPCFG_GCFG_MUXLOCK] <= gcfg_r[GPCFG_GCFG_MUXLOCK] | reg_wdata[GPCFG_GCFG_MUXLOCK];
            if (!gcfg_r[GPCFG_GCFG_MUXLOCK]) begin
                gcfg_r[0] <= reg_wdata[0];
            end
        end
    end

    // Pin mux follows its request until the global lock is set
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            pin_mux_sel <= '0;
        end else if (!mux_locked) begin
            pin_mux_sel <= pin_mux_req; // see [R10]
        end
    end

    assign cfg_old = cfg_all[slot_sel*8 +: 8];
    assign cfg_we = reg_wr && reg_addr == GPCFG_OFF_CFG && port_ok && slot_real(int'(slot_sel)); // see [R03] see [R20]
    assign rte_we = reg_wr && reg_addr == GPCFG_OFF_RTE && port_ok && has_event(port_sel); // see [R14] see [R20]

    // Locked bits 3-0 keep their old value; lock itself cannot be cleared
    always_comb begin
        cfg_wval = reg_wdata & cfg_mask(port_sel); // see [R08]
        if (cfg_old[GPCFG_CFG_LOCK]) begin
            cfg_wval = (cfg_wval & ~GPCFG_CFG_LOCKED) | (cfg_old & GPCFG_CFG_LOCKED); // see [R09]
        end
    end

    gpcfg_mem #(.DEPTH(N), .AW(6)) u_cfg (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .init_val(cfg_init),
        .we(cfg_we),
        .waddr(slot_sel),
        .wdata(cfg_wval),
        .raddr(slot_sel),
        .rdata(cfg_rd),
        .all_q(cfg_all)
    );

    gpcfg_mem #(.DEPTH(N), .AW(6)) u_rte (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .init_val(rte_init),
        .we(rte_we),
        .waddr(slot_sel),
        .wdata(reg_wdata & GPCFG_RTE_MASK),
        .raddr(slot_sel),
        .rdata(rte_rd),
        .all_q(rte_all)
    );

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rd_addr_r <= 8'h00;
            rd_ok_r <= 1'b0;
            rd_ev_r <= 1'b0;
        end else begin
            rd_addr_r <= reg_rd ? reg_addr : 8'h00;
            rd_ok_r <= port_ok && slot_real(int'(slot_sel));
            rd_ev_r <= has_event(port_sel);
        end
    end

    // Read data are valid only in the cycle after the strobe
    always_comb begin
        reg_rdata = 8'h00;
        if (rd_addr_r == GPCFG_OFF_SEL) begin
            reg_rdata = sel_r;
        end else if (rd_addr_r == GPCFG_OFF_CFG && rd_ok_r) begin
            reg_rdata = cfg_rd; // see [R03]
        end else if (rd_addr_r == GPCFG_OFF_RTE && rd_ok_r && rd_ev_r) begin
            reg_rdata = rte_rd; // see [R14]
        end else if (rd_addr_r == GPCFG_OFF_GCFG) begin
            reg_rdata = gcfg_r & (GPCFG_GCFG_MASK | 8'h80);
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            in_s1_r <= '0;
            in_s2_r <= '0;
            in_prev_r <= '0;
        end else begin
            in_s1_r <= pin_in;
            in_s2_r <= in_s1_r;
            in_prev_r <= in_deb_r;
        end
    end

    // Debounce: level must hold DEB_CYC cycles before it passes
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            in_deb_r <= '0;
            for (int s = 0; s < N; s++) begin
                deb_cnt_r[s] <= '0;
            end
        end else begin
            for (int s = 0; s < N; s++) begin
                if (!cfg_all[s*8 + GPCFG_CFG_DEB]) begin
                    in_deb_r[s] <= in_s2_r[s];
                    deb_cnt_r[s] <= '0; // see [R05]
                end else if (in_s2_r[s] == in_deb_r[s]) begin
                    deb_cnt_r[s] <= '0;
                end else if (deb_cnt_r[s] >= DW'(DEB_CYC - 1)) begin
                    in_deb_r[s] <= in_s2_r[s]; // see [R05]
                    deb_cnt_r[s] <= '0;
                end else begin
                    deb_cnt_r[s] <= deb_cnt_r[s] + 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            pin_event <= '0;
            ev_irq <= '0;
            ev_system_mgmt_interrupt <= '0;
            ev_power_up_request <= '0;
        end else begin
            for (int s = 0; s < N; s++) begin
                logic act;
                logic prv;
                logic ev;
                act = in_deb_r[s] ~^ cfg_all[s*8 + GPCFG_CFG_POL]; // see [R06]
                prv = in_prev_r[s] ~^ cfg_all[s*8 + GPCFG_CFG_POL];
                ev = cfg_all[s*8 + GPCFG_CFG_TYP] ? act : (act && !prv); // see [R07]
                ev = ev && ev_ok[s]; // see [R17]
                pin_event[s] <= ev;
                ev_irq[s] <= ev && rte_all[s*8 + GPCFG_RTE_IRQ]; // see [R15]
                ev_system_mgmt_interrupt[s] <= ev && rte_all[s*8 + GPCFG_RTE_SMI]; // see [R15]
                ev_power_up_request[s] <= ev && rte_all[s*8 + GPCFG_RTE_PWU]; // see [R15]
            end
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            pin_out <= '0;
            pin_oe <= '0;
            pin_pullup <= '0;
        end else begin
            for (int s = 0; s < N; s++) begin
                logic dv;
                dv = cfg_all[s*8 + GPCFG_CFG_LOCK] ? pin_out[s] : pin_dout[s]; // see [R09]
                // Open-drain drives only low; push-pull drives both levels
                pin_oe[s] <= cfg_all[s*8 + GPCFG_CFG_OE] && slot_real(s) &&
                    (cfg_all[s*8 + GPCFG_CFG_OT] || !dv); // see [R12] see [R13]
                pin_out[s] <= dv; // see [R09]
                pin_pullup[s] <= cfg_all[s*8 + GPCFG_CFG_PU] && slot_real(s); // see [R11]
            end
        end
    end

    property p_lock_holds;
        @(posedge clk_sys) disable iff (!arst_n)
        (reg_wr && reg_addr == GPCFG_OFF_CFG && cfg_old[GPCFG_CFG_LOCK] && port_ok)
            |=> (cfg_all[$past(slot_sel)*8 +: 4] == $past(cfg_old[3:0]));
    endproperty
    a_lock_holds: assert property (p_lock_holds) else $error("locked bits changed"); // see [R09]

    property p_out_frozen;
        @(posedge clk_sys) disable iff (!arst_n)
        cfg_all[2*8 + GPCFG_CFG_LOCK] |=> $stable(pin_out[2]);
    endproperty
    a_out_frozen: assert property (p_out_frozen) else $error("locked output value moved"); // see [R09]

    property p_resv_write;
        @(posedge clk_sys) disable iff (!arst_n)
        (reg_wr && !port_ok) |=> $stable(cfg_all) && $stable(rte_all);
    endproperty
    a_resv_write: assert property (p_resv_write) else $error("write at reserved port"); // see [R20]

    property p_noev_read;
        @(posedge clk_sys) disable iff (!arst_n)
        (reg_rd && reg_addr == GPCFG_OFF_CFG && (port_sel == 3'd2 || port_sel == 3'd3)) |=> reg_rdata[6:4] == 3'b000;
    endproperty
    a_noev_read: assert property (p_noev_read) else $error("reserved bits nonzero"); // see [R08]

    property p_rte_zero;
        @(posedge clk_sys) disable iff (!arst_n)
        (reg_rd && reg_addr == GPCFG_OFF_RTE && !has_event(port_sel)) |=> reg_rdata == 8'h00;
    endproperty
    a_rte_zero: assert property (p_rte_zero) else $error("routing read nonzero"); // see [R14]

    property p_sel_read;
        @(posedge clk_sys) disable iff (!arst_n)
        (reg_rd && reg_addr == GPCFG_OFF_SEL && !reg_wr) |=> reg_rdata == $past(sel_r);
    endproperty
    a_sel_read: assert property (p_sel_read) else $error("selector read wrong"); // see [R01]

    property p_oe_off;
        @(posedge clk_sys) disable iff (!arst_n)
        !cfg_all[GPCFG_CFG_OE] |=> !pin_oe[0];
    endproperty
    a_oe_off: assert property (p_oe_off) else $error("driver on while disabled"); // see [R13]

    property p_no_ev13;
        @(posedge clk_sys) disable iff (!arst_n)
        1'b1 |-> !pin_event[13];
    endproperty
    a_no_ev13: assert property (p_no_ev13) else $error("event on output-only pin"); // see [R17]

    property p_mux_frozen;
        @(posedge clk_sys) disable iff (!arst_n)
        mux_locked |=> $stable(pin_mux_sel);
    endproperty
    a_mux_frozen: assert property (p_mux_frozen) else $error("mux moved after lock"); // see [R10]
endmodule
`default_nettype wire

// ### sim/gpcfg_pin_model.sv
// Purpose: Board-side model of the general-purpose pins
// Assumes: A board driver loses to the block's own driver on the same pin
// Notes: A pin that nobody drives or pulls up wanders every cycle
`timescale 1ns/100ps
`default_nettype none
module gpcfg_pin_model (
    input wire logic clk_sys,
    input wire logic [39:0] pin_out,
    input wire logic [39:0] pin_oe,
    input wire logic [39:0] pin_pullup,
    input wire logic [39:0] ext_en,
    input wire logic [39:0] ext_val,
    output logic [39:0] pin_in
);
    logic float_r = 1'b0;
    always @(posedge clk_sys) begin
        float_r <= ~float_r;
    end
    // Floating pins toggle so a lost pull-up never reads as a clean level
    always_comb begin
        for (int i = 0; i < 40; i++) begin
            if (pin_oe[i]) begin
                pin_in[i] = pin_out[i];
            end else if (ext_en[i]) begin
                pin_in[i] = ext_val[i];
            end else if (pin_pullup[i]) begin
                pin_in[i] = 1'b1;
            end else begin
                pin_in[i] = float_r ^ i[0];
            end
        end
    end
endmodule
`default_nettype wire

// ### sim/tb_top.sv
// Purpose: Self-checking bench for the per-pin configuration block
// Assumes: Debounce shortened to a few cycles
// Notes: Directed corners first, then seeded random register traffic
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import gpcfg_pkg::*;
    localparam int DEB = 4;
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic [39:0] pin_in, pin_out, pin_oe, pin_pullup, pin_mux_sel, pin_event, ev_irq, ev_mgmt, ev_pwr, save;
    logic [39:0] pin_dout = '0;
    logic [39:0] pin_mux_req = '0;
    logic [39:0] ext_en = '1;
    logic [39:0] ext_val = '0;
    logic mux_locked;
    int bad_count = 0;
    int n_tests = 0;
    int ev_cnt = 0;
    int ev_base = 0;
    int s;
    logic [7:0] d, v;
    logic [7:0] cfg_m [40];
    logic [7:0] rte_m [40];
    logic [7:0] ct [4] = '{8'h07, 8'h01, 8'h01, 8'h06};
    logic dt [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
    logic ot [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
    logic ut [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
    logic [7:0] et [4] = '{8'h24, 8'h04, 8'h64, 8'h64};
    int eh [4] = '{20, 20, 2, 20};
    logic [7:0] ec [4] = '{8'h01, 8'h01, 8'h00, 8'h01};

    gpcfg_top #(.DEB_CYC(DEB)) gpcfg_top_inst (.clk_sys(clk_sys), .arst_n(arst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_in(pin_in),
        .pin_dout(pin_dout), .pin_mux_req(pin_mux_req), .pin_out(pin_out), .pin_oe(pin_oe),
        .pin_pullup(pin_pullup), .pin_mux_sel(pin_mux_sel), .pin_event(pin_event), .ev_irq(ev_irq),
        .ev_system_mgmt_interrupt(ev_mgmt), .ev_power_up_request(ev_pwr), .mux_locked(mux_locked));
    gpcfg_pin_model gpcfg_pin_model_inst (.clk_sys(clk_sys), .pin_out(pin_out), .pin_oe(pin_oe),
        .pin_pullup(pin_pullup), .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));

    initial begin
        forever #5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        if (pin_event[0] === 1'b1) begin
            ev_cnt <= ev_cnt + 1;
        end
    end

    function automatic logic [7:0] cfg_mask(input int n);
        if (n >= 29 && n <= 31) return 8'h00;
        return (n / 8 == 2 || n / 8 == 3) ? 8'h0f : 8'h7f;
    endfunction
    function automatic logic [7:0] rte_mask(input int n);
        return (n / 8 == 2 || n / 8 == 3) ? 8'h00 : 8'h07;
    endfunction
    // Locked pins keep the low four bits whatever is written
    function automatic logic [7:0] cfg_next(input logic [7:0] old, input logic [7:0] w, input int n);
        logic [7:0] r;
        r = w & cfg_mask(n);
        if (old[3]) r[3:0] = old[3:0];
        return r;
    endfunction
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] w);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= w;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] r);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(negedge clk_sys);
        r = reg_rdata;
    endtask
    task automatic sel(input int n);
        wr(8'hf0, {1'b0, 3'(n / 8), 1'b0, 3'(n % 8)});
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    task automatic do_reset();
        @(posedge clk_sys);
        arst_n <= 1'b0;
        repeat (10) @(posedge clk_sys);
        arst_n <= 1'b1;
        repeat (2) @(posedge clk_sys);
        for (int i = 0; i < 40; i++) begin
            cfg_m[i] = (cfg_mask(i) == 8'h7f) ? 8'h44 : (cfg_mask(i) & 8'h04);
            rte_m[i] = rte_mask(i) & 8'h01;
        end
    endtask
    task automatic check_all();
        logic [7:0] r;
        for (int i = 0; i < 40; i++) begin
            sel(i);
            rd(8'hf1, r);
            chk8(r, cfg_m[i]);
            rd(8'hf2, r);
            chk8(r, rte_m[i]);
        end
    endtask
    task automatic print_verdict();
        $display("Checks %0d, mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        #200000;
        bad_count++;
        print_verdict();
    end

    initial begin
        void'($urandom(32'hba41db06));
        do_reset();
        rd(8'hf0, d);
        chk8(d, 8'h00);
        check_all();
        wr(8'hf0, 8'hff);
        rd(8'hf0, d);
        chk8(d, 8'h77);
        rd(8'h30, d);
        chk8(d, 8'h00);
        for (int p = 5; p < 8; p++) begin
            wr(8'hf0, 8'(p * 16));
            wr(8'hf1, 8'h12);
            wr(8'hf2, 8'h07);
            rd(8'hf1, d);
            chk8(d, 8'h00);
            rd(8'hf2, d);
            chk8(d, 8'h00);
        end
        sel(0);
        rd(8'hf1, d);
        chk8(d, cfg_m[0]);
        sel(16);
        wr(8'hf1, 8'h77);
        rd(8'hf1, d);
        chk8(d, 8'h07);
        wr(8'hf2, 8'h07);
        rd(8'hf2, d);
        chk8(d, 8'h00);
        sel(1);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_sys);
            pin_dout[1] <= dt[i];
            wr(8'hf1, ct[i]);
            cyc(4);
            chk1(pin_oe[1], ot[i]);
            chk1(pin_pullup[1], ut[i]);
            chk1(pin_out[1], dt[i]);
        end
        @(posedge clk_sys);
        pin_dout[2] <= 1'b1;
        sel(2);
        wr(8'hf1, 8'h0f);
        @(posedge clk_sys);
        pin_dout[2] <= 1'b0;
        wr(8'hf1, 8'h40);
        rd(8'hf1, d);
        chk8(d, 8'h4f);
        cyc(4);
        chk1(pin_out[2], 1'b1);
        chk1(pin_oe[2], 1'b1);
        chk1(pin_pullup[2], 1'b1);
        @(posedge clk_sys);
        pin_mux_req <= 40'({$urandom(), $urandom()});
        cyc(4);
        chk8(pin_mux_sel[7:0], pin_mux_req[7:0]);
        wr(8'hf3, 8'h80);
        cyc(2);
        chk1(mux_locked, 1'b1);
        save = pin_mux_req;
        @(posedge clk_sys);
        pin_mux_req <= ~pin_mux_req;
        cyc(4);
        chk8(pin_mux_sel[7:0], save[7:0]);
        wr(8'hf3, 8'h00);
        cyc(2);
        chk1(mux_locked, 1'b1);
        sel(0);
        wr(8'hf1, 8'h34);
        cyc(DEB + 8);
        chk1(pin_event[0], 1'b0);
        @(posedge clk_sys);
        ext_val[0] <= 1'b1;
        cyc(DEB + 8);
        chk1(pin_event[0], 1'b1);
        chk1(ev_irq[0], 1'b1);
        chk1(ev_mgmt[0], 1'b0);
        wr(8'hf2, 8'h06);
        cyc(3);
        chk1(ev_irq[0], 1'b0);
        chk1(ev_mgmt[0], 1'b1);
        chk1(ev_pwr[0], 1'b1);
        wr(8'hf1, 8'h14);
        cyc(DEB + 8);
        chk1(pin_event[0], 1'b0);
        @(posedge clk_sys);
        ext_val[0] <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            wr(8'hf1, et[i]);
            cyc(DEB + 8);
            ev_base = ev_cnt;
            @(posedge clk_sys);
            ext_val[0] <= 1'b1;
            repeat (eh[i]) @(posedge clk_sys);
            ext_val[0] <= 1'b0;
            cyc(DEB + 12);
            chk8(8'(ev_cnt - ev_base), ec[i]);
        end
        sel(13);
        wr(8'hf1, 8'h34);
        @(posedge clk_sys);
        ext_val[13] <= 1'b1;
        cyc(DEB + 8);
        chk1(pin_event[13], 1'b0);
        do_reset();
        chk1(mux_locked, 1'b0);
        sel(2);
        rd(8'hf1, d);
        chk8(d, 8'h44);
        for (int i = 0; i < 80; i++) begin
            s = $urandom_range(39);
            if (s == 13) s = 12;
            v = 8'($urandom());
            sel(s);
            if ($urandom_range(1) == 1) begin
                wr(8'hf1, v);
                cfg_m[s] = cfg_next(cfg_m[s], v, s);
            end else begin
                wr(8'hf2, v);
                rte_m[s] = v & rte_mask(s);
            end
            rd(8'hf1, d);
            chk8(d, cfg_m[s]);
        end
        check_all();
        print_verdict();
    end
endmodule
`default_nettype wire
